/* rtl/ssp_map.svh */
// Purpose: register map, field positions and counts of the shift port
// Assumes: APB byte address is four times the register index
// Notes: definitions only
//
// Summary of operation
// - 8-bit shift register, 4-bit counter, MSB first
// - shift clock falling edge advances both
// - after eight edges, done output gates clocking
// - interrupt on eighth edge unless write reset
// - reset leaves interrupt disabled
// - data write enables, disable write disables
// - interrupt is a high-to-low transition
// - reset or data write clears counter
// - master mode: software toggles clock pin
// - serial input is input, output open-drain
// - open-drain mode connects shift output
// - software pulls data low as ninth-bit ack
// - slave may hold clock low to stretch
// - software polls lines for start and stop
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH
`define SSP_ADDR_W        10
`define SSP_IDX_DISABLE   8'hC2
`define SSP_IDX_SHIFT     8'hDD
`define SSP_IDX_CTRL      8'hE0
`define SSP_IDX_STATUS    8'hE1
`define SSP_BITS_DONE     4'h8
`define SSP_CNT_RESET     4'h0
`define SSP_BYTE_RESET    8'h00
`define SSP_CTRL_RESET    8'h14
`define SSP_CTRL_SCL_OUT  0
`define SSP_CTRL_SCL_OD   1
`define SSP_CTRL_SCL_LVL  2
`define SSP_CTRL_SOUT_OD  3
`define SSP_CTRL_SOUT_LVL 4
`define SSP_ERR_DATA      32'h0000_0000
`endif

/* rtl/ssp_pkg.sv */
// Purpose: shared types of the shift port
// Assumes: constants live in ssp_map.svh
// Notes: register strobes and views travel as structs
package ssp_pkg;
    // register writes decoded by the bus slave
    typedef struct packed {
        logic       wrShift;   // data register written
        logic       wrDisable; // disable register written
        logic       wrCtrl;    // pin control written
        logic [7:0] wdata;     // low byte of write data
    } ssp_req_t;
    // register contents shown to the bus slave
    typedef struct packed {
        logic [7:0] shiftData;   // shift register
        logic [7:0] disableData; // last disable value
        logic [7:0] ctrl;        // pin control
        logic [7:0] status;      // live state
    } ssp_view_t;
endpackage : ssp_pkg

/* rtl/ssp_pin_sync.sv */
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: pins are levels from outside the core clock
// Notes: first stage read only by the second
`timescale 1ns/1ps
module ssp_pin_sync import ssp_pkg::*; #(
    parameter int WIDTH = 3
) (
    input  wire logic             core_clk, // core clock
    input  wire logic             rst,      // sync reset
    input  wire logic [WIDTH-1:0] pinIn,    // raw pins
    output logic      [WIDTH-1:0] pinSync   // synced pins
);
    typedef struct packed {
        logic [WIDTH-1:0] meta; // first stage
        logic [WIDTH-1:0] sync; // second stage
    } ssp_sync_t;
    ssp_sync_t state_reg;       // state
    ssp_sync_t state_next;      // next state
    // one stage pair per pin
    always_comb begin
        state_next = state_reg;
        for (int i = 0; i < WIDTH; i++) begin
            state_next.meta[i] = pinIn[i];
            state_next.sync[i] = state_reg.meta[i];
        end
    end
    // register, idle high like pulled-up lines
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= '1;
        end else begin
            state_reg <= state_next;
        end
    end
    assign pinSync = state_reg.sync;
endmodule // ssp_pin_sync

/* rtl/ssp_apb_slave.sv */
// Purpose: APB slave for the shift port registers
// Assumes: zero wait states, one word per register
// Notes: read data captured in setup phase
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_apb_slave import ssp_pkg::*; (
    input  wire logic                   core_clk, // core clock
    input  wire logic                   rst,      // sync reset
    input  wire logic [`SSP_ADDR_W-1:0] paddr,    // byte address
    input  wire logic                   psel,     // select
    input  wire logic                   penable,  // access phase
    input  wire logic                   pwrite,   // write
    input  wire logic [31:0]            pwdata,   // write data
    output logic      [31:0]            prdata,   // read data
    output logic                        pready,   // ready
    output logic                        pslverr,  // unmapped
    input  wire ssp_view_t              view,     // register view
    output ssp_req_t                    req       // write strobes
);
    typedef struct packed {
        logic [31:0] rdata; // captured read data
        logic        err;   // unmapped address
    } ssp_apb_t;
    ssp_apb_t state_reg;   // state
    ssp_apb_t state_next;  // next state
    logic [7:0] idx;       // register index
    logic       aligned;   // low address bits zero
    logic       access;    // access phase
    assign idx     = paddr[`SSP_ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign access  = psel & penable;
    // setup phase: decode and capture read word
    always_comb begin
        state_next = state_reg;
        if (psel && !penable) begin
            state_next.err   = 1'b0;
            state_next.rdata = `SSP_ERR_DATA;
            if (!aligned) begin
                state_next.err = 1'b1;
            end else begin
                unique case (idx)
                    `SSP_IDX_SHIFT:   state_next.rdata[7:0] = view.shiftData;
                    `SSP_IDX_DISABLE: state_next.rdata[7:0] = view.disableData;
                    `SSP_IDX_CTRL:    state_next.rdata[7:0] = view.ctrl;
                    `SSP_IDX_STATUS:  state_next.rdata[7:0] = view.status;
                    default:          state_next.err = 1'b1;
                endcase
            end
        end
    end
    // register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
    // writes act at the access edge, status is read only
    always_comb begin
        req.wdata     = pwdata[7:0];
        req.wrShift   = access & pwrite & ~state_reg.err & (idx == `SSP_IDX_SHIFT);
        req.wrDisable = access & pwrite & ~state_reg.err & (idx == `SSP_IDX_DISABLE);
        req.wrCtrl    = access & pwrite & ~state_reg.err & (idx == `SSP_IDX_CTRL);
    end
    assign prdata  = state_reg.rdata;
    assign pready  = 1'b1;
    assign pslverr = access & state_reg.err;
endmodule // ssp_apb_slave

/* rtl/ssp_serial_shift_port.sv */
// Purpose: serial shift port with bit counter and edge interrupt
// Assumes: pins arrive asynchronously, APB on core_clk
// Notes: shift clock sampled by core clock, edges found by compare
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_serial_shift_port import ssp_pkg::*; (
    input  wire logic                   core_clk, // 40 MHz core clock
    input  wire logic                   rst,      // sync reset
    input  wire logic [`SSP_ADDR_W-1:0] paddr,    // APB address
    input  wire logic                   psel,     // APB select
    input  wire logic                   penable,  // APB enable
    input  wire logic                   pwrite,   // APB direction
    input  wire logic [31:0]            pwdata,   // APB write data
    output logic      [31:0]            prdata,   // APB read data
    output logic                        pready,   // APB ready
    output logic                        pslverr,  // APB error
    input  wire logic                   sclIn,    // clock pin level
    output logic                        sclOut,   // clock pin drive
    output logic                        sclOe,    // clock pin enable
    input  wire logic                   sinIn,    // serial input pin
    input  wire logic                   soutIn,   // serial output pin level
    output logic                        soutOut,  // serial output drive
    output logic                        soutOe,   // serial output enable
    output logic                        serialIrqN // falling-edge request
);
    // whole block state
    typedef struct packed {
        logic [7:0] shiftReg;    // data and shift register
        logic [3:0] bitCount;    // counted falling edges
        logic       irqEnable;   // interrupt armed
        logic       irqN;        // request line, idle high
        logic [7:0] disableReg;  // last disable write
        logic [7:0] ctrl;        // pin control
        logic       sclPrev;     // previous synced clock
        logic       sclOutQ;     // clock pin drive
        logic       sclOeQ;      // clock pin enable
        logic       soutOeQ;     // data pin enable
    } ssp_state_t;

    ssp_state_t state_reg;   // registered state
    ssp_state_t state_next;  // next state
    ssp_req_t   req;         // decoded writes
    ssp_view_t  view;        // readable contents
    logic [2:0] pinSync;     // synced scl, sin, sout
    logic       sclSync;     // synced clock pin
    logic       sinSync;     // synced serial input
    logic       soutSync;    // synced serial output pin
    logic       countDoneOut;// low once eight bits counted
    logic       sclFall;     // falling edge seen
    logic       shiftStep;   // counted edge
    logic       lastBit;     // this edge ends the byte

    // register bus
    ssp_apb_slave u_apb (
        .core_clk (core_clk),
        .rst      (rst),
        .paddr    (paddr),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .pwdata   (pwdata),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .view     (view),
        .req      (req)
    );

    // pins cross into the core clock
    ssp_pin_sync #(
        .WIDTH (3)
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pinIn    ({soutIn, sinIn, sclIn}),
        .pinSync  (pinSync)
    );

    assign sclSync  = pinSync[0];
    assign sinSync  = pinSync[1];
    assign soutSync = pinSync[2];

    // counter terminal output, low after eight pulses
    assign countDoneOut = (state_reg.bitCount != `SSP_BITS_DONE);

    // edge finder on the synced clock
    assign sclFall = state_reg.sclPrev & ~sclSync;

    // only edges while clocking is enabled count
    assign shiftStep = sclFall & countDoneOut;

    // the eighth counted edge
    assign lastBit = shiftStep
                   && (state_reg.bitCount == `SSP_BITS_DONE - 4'h1);

    // next-state logic
    always_comb begin
        state_next = state_reg;
        state_next.sclPrev = sclSync;

        // counted edge: shift toward MSB, capture input
        if (shiftStep) begin
            state_next.shiftReg = {state_reg.shiftReg[6:0], sinSync};
            state_next.bitCount = state_reg.bitCount + 4'h1;
        end

        // eighth edge drops the request line if armed
        if (lastBit && state_reg.irqEnable) begin
            state_next.irqN = 1'b0;
        end

        // disable write: clear wins, line released
        if (req.wrDisable) begin
            state_next.disableReg = req.wdata;
            state_next.irqEnable  = 1'b0;
            state_next.irqN       = 1'b1;
        end

        // data write: load, restart count, arm
        if (req.wrShift) begin
            state_next.shiftReg  = req.wdata;
            state_next.bitCount  = `SSP_CNT_RESET;
            state_next.irqEnable = 1'b1;
            state_next.irqN      = 1'b1;
        end

        // pin control write
        if (req.wrCtrl) begin
            state_next.ctrl = req.wdata;
        end

        // clock pin: input, push-pull or open-drain
        state_next.sclOutQ = state_next.ctrl[`SSP_CTRL_SCL_LVL];
        if (!state_next.ctrl[`SSP_CTRL_SCL_OUT]) begin
            state_next.sclOeQ = 1'b0;
        end else if (state_next.ctrl[`SSP_CTRL_SCL_OD]) begin
            state_next.sclOeQ = ~state_next.ctrl[`SSP_CTRL_SCL_LVL];
        end else begin
            state_next.sclOeQ = 1'b1;
        end

        // data pin open-drain: low when top bit or port bit is zero
        state_next.soutOeQ = state_next.ctrl[`SSP_CTRL_SOUT_OD]
                           & ~(state_next.shiftReg[7]
                               & state_next.ctrl[`SSP_CTRL_SOUT_LVL]);
    end

    // state register, reset clears counter and disarms
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg.shiftReg   <= `SSP_BYTE_RESET;
            state_reg.bitCount   <= `SSP_CNT_RESET;
            state_reg.irqEnable  <= 1'b0;
            state_reg.irqN       <= 1'b1;
            state_reg.disableReg <= `SSP_BYTE_RESET;
            state_reg.ctrl       <= `SSP_CTRL_RESET;
            state_reg.sclPrev    <= 1'b1;
            state_reg.sclOutQ    <= 1'b1;
            state_reg.sclOeQ     <= 1'b0;
            state_reg.soutOeQ    <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // register view for reads, status lets software poll lines
    always_comb begin
        view.shiftData   = state_reg.shiftReg;
        view.disableData = state_reg.disableReg;
        view.ctrl        = state_reg.ctrl;
        view.status      = {soutSync, sclSync, sinSync, state_reg.irqEnable,
                            countDoneOut, state_reg.bitCount[2:0]};
    end

    // pin drivers, open-drain pins only ever pull low
    assign sclOut     = state_reg.sclOutQ;
    assign sclOe      = state_reg.sclOeQ;
    assign soutOut    = 1'b0;
    assign soutOe     = state_reg.soutOeQ;
    assign serialIrqN = state_reg.irqN;
endmodule // ssp_serial_shift_port

/* verification/ssp_port_properties.sv */
// Purpose: port-level checker of the shift port
// Assumes: byte address is four times the register index
// Notes: bound to the top module below
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_port_properties import ssp_pkg::*; (
    input wire logic                   core_clk,  // core clock
    input wire logic                   rst,       // sync reset
    input wire logic [`SSP_ADDR_W-1:0] paddr,     // address
    input wire logic                   psel,      // select
    input wire logic                   penable,   // access phase
    input wire logic                   pwrite,    // direction
    input wire logic [31:0]            pwdata,    // write data
    input wire logic                   pready,    // ready
    input wire logic                   pslverr,   // error
    input wire logic                   sclIn,     // clock line
    input wire logic                   sclOut,    // clock drive
    input wire logic                   sclOe,     // clock enable
    input wire logic                   soutOut,   // data drive
    input wire logic                   soutOe,    // data enable
    input wire logic                   serialIrqN // request
);
    logic wr;     // write taken
    logic wrData; // data register write
    logic wrDis;  // disable register write
    logic wrCtl;  // pin control write
    assign wr = psel && penable && pwrite;
    assign wrData = wr && paddr == 10'h374;
    assign wrDis = wr && paddr == 10'h308;
    assign wrCtl = wr && paddr == 10'h380;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_irq_reset: assert property (disable iff (1'b0) rst |=> serialIrqN)
        else $error("request low after reset");
    a_irq_rearm: assert property (wrData || wrDis |=> serialIrqN)
        else $error("request low after register write");
    a_irq_fall: assert property ($fell(serialIrqN) |-> !$past(sclIn) && !$past(sclIn, 2))
        else $error("request fell without clock fall");
    a_irq_hold: assert property (!serialIrqN && !wrData && !wrDis |=> !serialIrqN)
        else $error("request released without write");
    a_sout_drain: assert property (soutOut == 1'b0)
        else $error("data pin driven high");
    a_ack_pull: assert property (wrCtl && pwdata[4:3] == 2'b01 |=> soutOe)
        else $error("data line not pulled low");
    a_sout_off: assert property (wrCtl && !pwdata[3] |=> !soutOe)
        else $error("data line driven while unused");
    a_scl_drive: assert property (wrCtl && pwdata[1:0] == 2'b01 |=>
        sclOe && sclOut == $past(pwdata[2]))
        else $error("clock pin not driven");
    a_scl_input: assert property (wrCtl && !pwdata[0] |=> !sclOe)
        else $error("clock pin driven as input");
    a_scl_stretch: assert property (wrCtl && pwdata[2:0] == 3'b011 |=> sclOe && !sclOut)
        else $error("clock pin not held low");
    a_err_map: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    a_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    a_ready_up: assert property (psel && penable |-> pready)
        else $error("ready low in access phase");
endmodule // ssp_port_properties
bind ssp_serial_shift_port ssp_port_properties ssp_port_properties_inst (.core_clk, .rst,
    .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr, .sclIn, .sclOut,
    .sclOe, .soutOut, .soutOe, .serialIrqN);

/* verification/ssp_link_master.sv */
// Purpose: external serial master driving the shift clock
// Assumes: clock stands high between frames
// Notes: 4 core cycles high, 4 low per bit
`timescale 1ns/1ps
module ssp_link_master (
    input  wire logic       core_clk, // bench clock
    input  wire logic       go,       // frame start
    input  wire logic [3:0] nBits,    // bits in frame
    input  wire logic [7:0] txByte,   // byte sent msb first
    input  wire logic       sdaLine,  // serial output line
    output logic            sclLine,  // shift clock
    output logic            sinLine,  // serial input line
    output logic            busy,     // frame running
    output logic [7:0]      rxByte    // bits seen on line
);
    initial begin
        sclLine = 1'b1;
        sinLine = 1'b0;
        busy = 1'b0;
        rxByte = 8'h00;
    end
    // one frame per start, data set while clock high
    always begin
        @(posedge core_clk);
        if (go) begin
            busy <= 1'b1;
            for (int i = 0; i < nBits; i++) begin
                sinLine <= txByte[7 - i];
                sclLine <= 1'b1;
                repeat (4) @(posedge core_clk);
                rxByte <= {rxByte[6:0], sdaLine};
                sclLine <= 1'b0;
                repeat (4) @(posedge core_clk);
            end
            sclLine <= 1'b1; // clock stands high between frames
            sinLine <= ~sinLine; // released line shows no stale bit
            busy <= 1'b0;
        end
    end
endmodule // ssp_link_master

/* verification/tb.sv */
// Purpose: self-checking bench of the shift port
// Assumes: APB master, external clock master model
// Notes: model of counter, shifter and request
`timescale 1ns/1ps
module tb;
    logic       core_clk, rst, psel, penable, pwrite, go, busy;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, seed, v;
    logic       pready, pslverr, sclOut, sclOe, soutOut, soutOe, serialIrqN;
    logic       sclLine, sinLine, sda, sclW;
    logic [3:0] nBits;
    logic [7:0] txb, rxb, r, mShift, mRx;
    logic       e, mArmed, mIrq, mLvl;
    int         mCount, checked, miscompares;
    assign sda = soutOe ? soutOut : 1'b1; // pull-up on shared data line
    assign sclW = sclLine & ~(sclOe & ~sclOut);
    ssp_serial_shift_port ssp_serial_shift_port_inst (.core_clk, .rst, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .sclIn(sclW), .sclOut,
        .sclOe, .sinIn(sinLine), .soutIn(sda), .soutOut, .soutOe, .serialIrqN);
    ssp_link_master ssp_link_master_inst (.core_clk, .go, .nBits, .txByte(txb),
        .sdaLine(sda), .sclLine, .sinLine, .busy, .rxByte(rxb));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic finish_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
        checked++;
        if (g !== x) begin
            $display("[FAIL] %s exp %h got %h", nm, x, g);
            miscompares++;
        end
    endtask
    // one APB transfer, answer taken at the rising edge where pready is high
    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            miscompares++;
        end
    endtask
    // register write plus model update
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
        if (a == 10'h374) begin
            mShift = d;
            mCount = 0;
            mArmed = 1'b1;
            mIrq = 1'b1;
        end
        if (a == 10'h308) begin
            mArmed = 1'b0;
            mIrq = 1'b1;
        end
        if (a == 10'h380) mLvl = d[4];
        @(negedge core_clk); // let registered outputs settle before checks
    endtask
    // model of one falling clock edge
    task automatic m_edge(input logic b);
        mRx = {mRx[6:0], mLvl & mShift[7]};
        if (mCount < 8) begin
            mShift = {mShift[6:0], b};
            mCount++;
            if (mCount == 8 && mArmed) mIrq = 1'b0;
        end
    endtask
    task automatic st();
        apb(1'b0, 10'h384, 8'h00);
        chk("status", {3'h0, mArmed, mCount < 8, mCount[2:0]}, {3'h0, r[4:0]});
        apb(1'b0, 10'h374, 8'h00);
        chk("data", mShift, r);
        chk("irq", {7'h00, mIrq}, {7'h00, serialIrqN});
    endtask
    task automatic send(input logic [7:0] t, input int n);
        int k;
        @(posedge core_clk);
        txb <= t;
        nBits <= n[3:0];
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (busy !== 1'b0 && k < 200);
        if (k >= 200) begin
            miscompares++;
        end
        for (int i = 0; i < n; i++) m_edge(t[7 - i]);
        chk("sout", mRx, rxb);
        st();
    endtask
    // watchdog on a hang
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        finish_test();
    end
    initial begin
        {rst, psel, penable, pwrite, go} = 5'h10;
        paddr = 10'h000;
        pwdata = 32'h00000000;
        {nBits, txb, mShift, mRx} = 28'h0000000;
        {mArmed, mIrq, mLvl} = 3'h3;
        mCount = 0;
        checked = 0;
        miscompares = 0;
        seed = 32'h2EC2;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, 10'h380, 8'h00);
        chk("ctrl", 8'h14, r);
        st();
        apb(1'b0, 10'h000, 8'h00);
        chk("err", 8'h01, {7'h00, e});
        apb(1'b1, 10'h375, 8'hFF);
        chk("err", 8'h01, {7'h00, e});
        wr(10'h380, 8'h18);
        for (int j = 0; j < 4; j++) begin
            v = xs();
            wr(10'h374, v[7:0]);
            v = xs();
            send(v[7:0], 8);
            wr(10'h380, 8'h08);
            chk("ack", 8'h01, {7'h00, soutOe});
            send(8'hFF, 1);
            wr(10'h380, 8'h18);
        end
        v = xs();
        wr(10'h374, v[7:0]);
        send(v[15:8], 4);
        wr(10'h374, v[23:16]);
        send(v[31:24], 7);
        send(v[7:0], 1);
        wr(10'h308, 8'h5A);
        st();
        wr(10'h374, v[15:8]);
        wr(10'h308, 8'h00);
        send(v[23:16], 8);
        wr(10'h380, 8'h05);
        chk("scl", 8'h03, {6'h00, sclOe, sclOut});
        chk("sout", 8'h00, {7'h00, soutOe});
        wr(10'h380, 8'h03);
        chk("stretch", 8'h02, {6'h00, sclOe, sclOut});
        wr(10'h380, 8'h18);
        chk("scl", 8'h00, {7'h00, sclOe});
        finish_test();
    end
endmodule // tb
